// file: src/flex_pack_pkg.sv
// Shared constants and carriers for the pack supply configuration block.
// Assumes a 32-bit AXI4-Lite master; every register is one 16-bit word.
package flex_pack_pkg;
    localparam int REG_W = 16;
    localparam int TRIM_WORDS = 11;
    // Byte addresses
    localparam logic [7:0] ADDR_PACK_SETUP = 8'h00;
    localparam logic [7:0] ADDR_ACQ_CTRL = 8'h04;
    localparam logic [7:0] ADDR_ROUTE_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RESULT = 8'h0c;
    localparam logic [7:0] ADDR_PART_CODE = 8'h10;
    localparam logic [7:0] ADDR_SERIAL_LOW = 8'h14;
    localparam logic [7:0] ADDR_SERIAL_HIGH = 8'h18;
    localparam logic [7:0] ADDR_SAMPLE = 8'h1c;
    localparam logic [7:0] ADDR_TRIM_BASE = 8'h40;
    // Pack setup field positions
    localparam int PS_SEL_A_LSB = 0;
    localparam int PS_SEL_B_LSB = 4;
    localparam int PS_BLOCK_LSB = 8;
    localparam int PS_EN_A_BIT = 12;
    localparam int PS_EN_B_BIT = 13;
    // Acquisition control field positions
    localparam int AC_START_BIT = 0;
    localparam int AC_OVERSAMPLE_BIT = 1;
    localparam int AC_SINGLE_SCAN_BIT = 2;
    localparam int AC_CAL_VALID_BIT = 3;
    localparam int AC_OSR_LSB = 4;
    localparam int AC_CHEN_LSB = 8;
    localparam int NUM_CH = 8;
    // Selector codes
    localparam logic [3:0] SEL_OFF = 4'h0;
    localparam logic [3:0] SEL_UNSUP_MAX = 4'h7;
    localparam logic [3:0] SEL_BLOCK_PIN = 4'hf;
    localparam logic [15:0] PACK_SETUP_RST = 16'h3f00;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic enable;
        logic [3:0] cellSel;
        logic [3:0] blockSel;
    } route_s;

    typedef struct packed {
        logic [11:0] code;
        logic valid;
    } conv_s;
endpackage

// file: src/flex_pack_supply_config.sv
// Pack supply routing, identity and acquisition sequencing with AXI4-Lite.
// Assumes a synchronous conversion source on the same clock.
// Functional notes
// - Every software register is a sixteen-bit word.
// - Eleven trim words are read-only; writes never change them.
// - Trim checksum byte sits in the upper byte of the last trim word.
// - Two read-only words form the 32-bit serial; zero means invalid.
// - Serial is unique per kind and revision; together they identify parts.
// - Supply routing enable comes up asserted after power-on.
// - Top-cell codes 0..7 and F are unsupported and map to off.
// - Mismatched redundant enables or top-cell selectors apply power-on defaults.
// - Block tap connects only after selectors defined and enables asserted.
// - Block selector picks cell pin; F and 0..7 select the block pin.
// - Supply power-on reset returns routing enables to power-on state.
// - A conversion samples one channel into a 12-bit arithmetic register.
// - A scan converts every enabled channel in turn, skipping disabled ones.
// - A measurement cycle is two scans combined, or one scan in single-scan mode.
// - Oversampling sums measurements into 14 bits; otherwise one cycle.
// - Single-scan mode is allowed only with valid calibration.
module flex_pack_supply_config #(
    parameter logic [15:0] SERIAL_LOW = 16'h1234, // Arbitrary value
    parameter logic [15:0] SERIAL_HIGH = 16'h00a5, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h0101, // Arbitrary value
    parameter logic [7:0] TRIM_CRC = 8'h5a, // Arbitrary value
    parameter logic [159:0] TRIM_LOW = '0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [11:0] convCode,
    input wire logic convDone,
    output logic convStart,
    output logic [2:0] convChannel,
    output logic packRouteEnable,
    output logic [3:0] highestCellSelect,
    output logic [3:0] blockTapSelect,
    output logic blockTapConnect,
    output logic acqBusy
);
    localparam logic [175:0] TRIM_ALL = {TRIM_CRC, 8'h00, TRIM_LOW};

    logic [15:0] packSetup_r;
    logic [15:0] acqCtrl_r;
    flex_pack_pkg::route_s route_r;
    logic [7:0] awAddr_r, arAddr_r;
    logic awHeld_r, wHeld_r, arHeld_r, rPend_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic [15:0] trimData;
    logic [15:0] result_r;
    logic [15:0] sample_r;
    logic doWrite, singleOk;
    logic [15:0] wordNxt;

    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign wordNxt = {wStrb_r[1] ? wData_r[15:8] : packSetup_r[15:8],
                      wStrb_r[0] ? wData_r[7:0] : packSetup_r[7:0]};

    // Write address/data taken in either order, response after both
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0;
            wStrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= flex_pack_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Trim and identity words answer with an error
                s_axi_bresp <= (awAddr_r == flex_pack_pkg::ADDR_PACK_SETUP ||
                    awAddr_r == flex_pack_pkg::ADDR_ACQ_CTRL) ?
                    flex_pack_pkg::RESP_OKAY : flex_pack_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Setup word; power-on reset loads 16'h3f00, writes force bits 15:14 low
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            packSetup_r <= flex_pack_pkg::PACK_SETUP_RST;
        else if (doWrite && awAddr_r == flex_pack_pkg::ADDR_PACK_SETUP)
            packSetup_r <= {2'b00, wordNxt[13:0]};
    end

    function automatic logic [3:0] cellMap(input logic [3:0] code);
        if (code <= flex_pack_pkg::SEL_UNSUP_MAX ||
            code == flex_pack_pkg::SEL_BLOCK_PIN)
            cellMap = flex_pack_pkg::SEL_OFF;
        else
            cellMap = code;
    endfunction

    function automatic logic [3:0] blockMap(input logic [3:0] code);
        if (code <= flex_pack_pkg::SEL_UNSUP_MAX)
            blockMap = flex_pack_pkg::SEL_BLOCK_PIN;
        else
            blockMap = code;
    endfunction

    // Effective routing follows the setup word only when copies agree
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            route_r.enable <= 1'b1;
            route_r.cellSel <= flex_pack_pkg::SEL_OFF;
            route_r.blockSel <= flex_pack_pkg::SEL_BLOCK_PIN;
        end
        else if (packSetup_r[flex_pack_pkg::PS_EN_A_BIT] !=
                 packSetup_r[flex_pack_pkg::PS_EN_B_BIT] ||
                 packSetup_r[flex_pack_pkg::PS_SEL_A_LSB +: 4] !=
                 packSetup_r[flex_pack_pkg::PS_SEL_B_LSB +: 4])
        begin
            route_r.enable <= 1'b1;
            route_r.cellSel <= flex_pack_pkg::SEL_OFF;
            route_r.blockSel <= flex_pack_pkg::SEL_BLOCK_PIN;
        end
        else
        begin
            route_r.enable <= packSetup_r[flex_pack_pkg::PS_EN_A_BIT];
            route_r.cellSel <= cellMap(
                packSetup_r[flex_pack_pkg::PS_SEL_A_LSB +: 4]);
            route_r.blockSel <= blockMap(
                packSetup_r[flex_pack_pkg::PS_BLOCK_LSB +: 4]);
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            packRouteEnable <= 1'b1;
            highestCellSelect <= flex_pack_pkg::SEL_OFF;
            blockTapSelect <= flex_pack_pkg::SEL_BLOCK_PIN;
            blockTapConnect <= 1'b0;
        end
        else
        begin
            packRouteEnable <= route_r.enable;
            highestCellSelect <= route_r.cellSel;
            blockTapSelect <= route_r.blockSel;
            // Tap only when a real top cell is set and routing is on
            blockTapConnect <= route_r.enable &&
                route_r.cellSel != flex_pack_pkg::SEL_OFF &&
                route_r.blockSel != flex_pack_pkg::SEL_BLOCK_PIN;
        end
    end

    // Acquisition sequencer
    typedef enum logic [2:0] {IDLE, PICK, CONV, WAIT, NEXT} acq_e;
    acq_e state_r;
    logic [2:0] ch_r;
    logic scan_r;
    logic [7:0] meas_r;
    logic [19:0] acc_r;
    logic [15:0] ctl;
    logic [15:0] acqCtrl_nxt;
    logic startReq;

    assign ctl = acqCtrl_r;
    // Own merge: unstrobed lanes must keep this word, not the setup word
    assign acqCtrl_nxt = {wStrb_r[1] ? wData_r[15:8] : acqCtrl_r[15:8],
                          wStrb_r[0] ? wData_r[7:0] : acqCtrl_r[7:0]};
    assign singleOk = ctl[flex_pack_pkg::AC_SINGLE_SCAN_BIT] &&
                      ctl[flex_pack_pkg::AC_CAL_VALID_BIT];
    assign startReq = doWrite && awAddr_r == flex_pack_pkg::ADDR_ACQ_CTRL &&
                      wStrb_r[0] && wData_r[flex_pack_pkg::AC_START_BIT];

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            acqCtrl_r <= 16'h0000;
        else if (doWrite && awAddr_r == flex_pack_pkg::ADDR_ACQ_CTRL &&
                 state_r == IDLE)
            acqCtrl_r <= {acqCtrl_nxt[15:1], 1'b0};
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= IDLE;
            ch_r <= 3'd0;
            scan_r <= 1'b0;
            meas_r <= 8'h00;
            acc_r <= 20'h0;
            convStart <= 1'b0;
            convChannel <= 3'd0;
            acqBusy <= 1'b0;
            result_r <= 16'h0000;
            sample_r <= 16'h0000;
        end
        else
        begin
            convStart <= 1'b0;
            unique case (state_r)
                IDLE:
                    // Enables of the word being written, not the old one
                    if (startReq &&
                        acqCtrl_nxt[flex_pack_pkg::AC_CHEN_LSB +: 8] != 8'h00)
                    begin
                        state_r <= PICK;
                        ch_r <= 3'd0;
                        scan_r <= 1'b0;
                        meas_r <= 8'h00;
                        acc_r <= 20'h0;
                        acqBusy <= 1'b1;
                    end
                PICK:
                    if (ctl[flex_pack_pkg::AC_CHEN_LSB + int'(ch_r)])
                        state_r <= CONV;
                    else
                        state_r <= NEXT;
                CONV:
                begin
                    convStart <= 1'b1;
                    convChannel <= ch_r;
                    state_r <= WAIT;
                end
                WAIT:
                    if (convDone)
                    begin
                        result_r <= {4'h0, convCode};
                        acc_r <= acc_r + 20'(convCode);
                        state_r <= NEXT;
                    end
                NEXT:
                    if (ch_r != 3'(flex_pack_pkg::NUM_CH - 1))
                    begin
                        ch_r <= ch_r + 3'd1;
                        state_r <= PICK;
                    end
                    else if (!scan_r && !singleOk)
                    begin
                        scan_r <= 1'b1;
                        ch_r <= 3'd0;
                        state_r <= PICK;
                    end
                    else if (ctl[flex_pack_pkg::AC_OVERSAMPLE_BIT] &&
                             meas_r[3:0] != ctl[flex_pack_pkg::AC_OSR_LSB +: 4])
                    begin
                        meas_r <= meas_r + 8'h01;
                        scan_r <= 1'b0;
                        ch_r <= 3'd0;
                        state_r <= PICK;
                    end
                    else
                    begin
                        // Running sum cut to its low 14 bits, left aligned
                        sample_r <= {acc_r[13:0], 2'b00};
                        acqBusy <= 1'b0;
                        state_r <= IDLE;
                    end
            endcase
        end
    end

    trim_rom #(.WORDS(flex_pack_pkg::TRIM_WORDS), .CONTENTS(TRIM_ALL)) u_trim (
        .clock(clock),
        .nrst(nrst),
        .index(4'(s_axi_araddr[5:2])),
        .data(trimData)
    );

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b0;
            arHeld_r <= 1'b0;
            rPend_r <= 1'b0;
            arAddr_r <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= flex_pack_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !arHeld_r && !s_axi_arready && s_axi_arvalid &&
                             !s_axi_rvalid;
            rPend_r <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                arHeld_r <= 1'b1;
                arAddr_r <= s_axi_araddr;
                rPend_r <= 1'b1;
            end
            if (rPend_r)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= flex_pack_pkg::RESP_OKAY;
                if (arAddr_r >= flex_pack_pkg::ADDR_TRIM_BASE &&
                    arAddr_r < flex_pack_pkg::ADDR_TRIM_BASE + 8'd44)
                    s_axi_rdata <= {16'h0, trimData};
                else
                    unique case (arAddr_r)
                        flex_pack_pkg::ADDR_PACK_SETUP:
                            s_axi_rdata <= {16'h0, packSetup_r};
                        flex_pack_pkg::ADDR_ACQ_CTRL:
                            s_axi_rdata <= {16'h0, acqCtrl_r};
                        flex_pack_pkg::ADDR_ROUTE_STATUS:
                            s_axi_rdata <= {21'h0, acqBusy, blockTapConnect,
                                route_r.enable, route_r.blockSel,
                                route_r.cellSel};
                        flex_pack_pkg::ADDR_RESULT:
                            s_axi_rdata <= {16'h0, result_r};
                        flex_pack_pkg::ADDR_PART_CODE:
                            s_axi_rdata <= {16'h0, PART_CODE};
                        flex_pack_pkg::ADDR_SERIAL_LOW:
                            s_axi_rdata <= {16'h0, SERIAL_LOW};
                        flex_pack_pkg::ADDR_SERIAL_HIGH:
                            s_axi_rdata <= {16'h0, SERIAL_HIGH};
                        flex_pack_pkg::ADDR_SAMPLE:
                            s_axi_rdata <= {16'h0, sample_r};
                        default:
                        begin
                            s_axi_rdata <= 32'h0;
                            s_axi_rresp <= flex_pack_pkg::RESP_SLVERR;
                        end
                    endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                arHeld_r <= 1'b0;
            end
        end
    end

    a_mismatch_default: assert property (@(posedge clock) disable iff (!nrst)
        (packSetup_r[12] != packSetup_r[13]) |=> route_r.enable &&
        route_r.cellSel == 4'h0) else $error("mismatch not defaulted");
    a_cell_unsup_off: assert property (@(posedge clock) disable iff (!nrst)
        route_r.cellSel != 4'hf && !(route_r.cellSel inside {[4'h1:4'h7]}))
        else $error("unsupported top cell code");
    a_block_unsup: assert property (@(posedge clock) disable iff (!nrst)
        !(route_r.blockSel inside {[4'h0:4'h7]}))
        else $error("unsupported block code");
    a_tap_needs_route: assert property (@(posedge clock) disable iff (!nrst)
        blockTapConnect |-> $past(route_r.enable) && $past(route_r.cellSel) != 0)
        else $error("tap without route");
    a_agree_update: assert property (@(posedge clock) disable iff (!nrst)
        (packSetup_r[12] == packSetup_r[13] &&
         packSetup_r[3:0] == packSetup_r[7:4]) |=>
        route_r.enable == $past(packSetup_r[12]))
        else $error("agreed copy not applied");
    a_conv_result: assert property (@(posedge clock) disable iff (!nrst)
        (state_r == WAIT && convDone) |=> result_r == {4'h0, $past(convCode)})
        else $error("result not stored");
    a_skip_disabled: assert property (@(posedge clock) disable iff (!nrst)
        convStart |-> ctl[8 + int'(convChannel)])
        else $error("disabled channel converted");
    a_trim_ro: assert property (@(posedge clock) disable iff (!nrst)
        (doWrite && awAddr_r >= 8'h10) |=> s_axi_bresp == 2'b10)
        else $error("read-only write accepted");
    a_reg_width: assert property (@(posedge clock) disable iff (!nrst)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper bits set");
    a_single_cal: assert property (@(posedge clock) disable iff (!nrst)
        (state_r == NEXT && ch_r == 3'd7 && !scan_r && !singleOk) |=>
        scan_r) else $error("second scan skipped");

    c_acq_done: cover property (@(posedge clock) $fell(acqBusy));
    c_tap_on: cover property (@(posedge clock) $rose(blockTapConnect));
    c_mismatch: cover property (@(posedge clock) packSetup_r[12] !=
        packSetup_r[13]);
    c_oversample: cover property (@(posedge clock) meas_r == 8'h02);
endmodule

// file: src/trim_rom.sv
// Read-only trim word bank with a registered read port.
// Contents are fixed by parameter; no write path exists at all.
module trim_rom #(
    parameter int WORDS = 11,
    parameter logic [WORDS*16-1:0] CONTENTS = '0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] index,
    output logic [15:0] data
);
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            data <= 16'h0000;
        else if (int'(index) < WORDS)
            data <= CONTENTS[index*16 +: 16];
        else
            data <= 16'h0000;
    end
endmodule

// file: tb/flex_pack_supply_config_tb.sv
// Self-checking bench for the pack supply configuration block.
// Assumes the register map and bus latencies of the block.
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    err_total++; $display("wrong value %s exp %h got %h", nm, ex, got); \
    end end
module flex_pack_supply_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, nrst = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, convDone = 0, convStart;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0, highestCellSelect, blockTapSelect;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, packRouteEnable, blockTapConnect, acqBusy;
    logic [11:0] convCode = 0, lastCode = 0;
    logic [2:0] convChannel;
    logic [31:0] rnd = 32'h8a0b5968;
    logic [33:0] rdExp[$], rdMask[$];
    logic [1:0] wrExp[$];
    int err_total = 0, num_checks = 0, nConv = 0;
    logic [1:0] bExp;
    logic [33:0] rdE, rdM;
    logic [13:0] codeSum = 0;
    logic [2:0] expCh;
    logic [9:0] routeOut;
    assign routeOut = {packRouteEnable, highestCellSelect, blockTapSelect,
        blockTapConnect};
    always #4 clock = ~clock;
    flex_pack_supply_config #(.SERIAL_LOW(16'h2468), .SERIAL_HIGH(16'h0137),
        .PART_CODE(16'h0202), .TRIM_CRC(8'h3c), // Arbitrary identity values
        .TRIM_LOW({144'h0, 16'hbeef})) dut (.clock(clock), .nrst(nrst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .convCode(convCode),
        .convDone(convDone), .convStart(convStart),
        .convChannel(convChannel), .packRouteEnable(packRouteEnable),
        .highestCellSelect(highestCellSelect),
        .blockTapSelect(blockTapSelect), .blockTapConnect(blockTapConnect),
        .acqBusy(acqBusy));
    function automatic logic [31:0] nextRnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Upper lanes carry noise; the block must ignore them
    task automatic axiWrite(input logic [7:0] a, input logic [15:0] d,
        input logic [1:0] resp);
        wrExp.push_back(resp);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= {rnd[31:16], d};
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        rnd = nextRnd(rnd);
        do
        begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task automatic axiRead(input logic [7:0] a, input logic [33:0] ex,
        input logic [33:0] m);
        rdExp.push_back(ex);
        rdMask.push_back(m);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    // Result watcher: oldest note pairs with each completed response
    always @(posedge clock)
    begin
        // Pop once: the macro names its arguments more than once
        if (s_axi_bvalid && s_axi_bready)
        begin
            bExp = wrExp.pop_front();
            `CHK("bresp", bExp, s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            rdE = rdExp.pop_front();
            rdM = rdMask.pop_front();
            `CHK("rdata", rdE & rdM, {s_axi_rresp, s_axi_rdata} & rdM)
        end
    end
    // Conversion source: answers two cycles after each start pulse
    initial forever
    begin
        @(posedge clock);
        if (convStart)
        begin
            expCh = (nConv % 2 == 1 && nConv < 4) ? 3'd2 : 3'd0;
            `CHK("channel", expCh, convChannel)
            nConv++;
            repeat (2) @(posedge clock);
            lastCode = rnd[11:0];
            codeSum = codeSum + 14'(lastCode);
            rnd = nextRnd(rnd);
            convCode <= lastCode;
            convDone <= 1;
            @(posedge clock);
            convDone <= 0;
            convCode <= ~lastCode;
        end
    end
    task automatic route(input logic [15:0] w, input logic [9:0] ex);
        axiWrite(flex_pack_pkg::ADDR_PACK_SETUP, w, flex_pack_pkg::RESP_OKAY);
        repeat (3) @(posedge clock);
        `CHK("routeOut", ex, routeOut)
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        finish_test();
    end
    initial
    begin
        repeat (8) @(posedge clock);
        nrst <= 1;
        `CHK("rstOut", 10'h21e, routeOut)
        axiRead(flex_pack_pkg::ADDR_PACK_SETUP, 34'h3f00, '1);
        axiRead(flex_pack_pkg::ADDR_PART_CODE, 34'h0202, '1);
        axiRead(flex_pack_pkg::ADDR_SERIAL_LOW, 34'h2468, '1);
        axiRead(flex_pack_pkg::ADDR_SERIAL_HIGH, 34'h0137, '1);
        axiRead(8'h68, 34'h3c00, 34'h3ffff00);
        axiWrite(8'h40, 16'h1234, flex_pack_pkg::RESP_SLVERR);
        axiRead(8'h40, 34'hbeef, '1);
        axiWrite(8'h80, 16'h0001, flex_pack_pkg::RESP_SLVERR);
        axiRead(8'h80, {flex_pack_pkg::RESP_SLVERR, 32'h0}, '1);
        route(16'h3acc, 10'h395);
        route(16'h3adc, 10'h21e);
        axiRead(flex_pack_pkg::ADDR_PACK_SETUP, 34'h3adc, '1);
        route(16'h1acc, 10'h21e);
        route(16'h3a55, 10'h214);
        route(16'h39ff, 10'h212);
        route(16'h3388, 10'h31e);
        route(16'h3fee, 10'h3de);
        route(16'h0acc, 10'h194);
        nrst <= 0;
        @(posedge clock);
        nrst <= 1;
        @(posedge clock);
        `CHK("porOut", 10'h21e, routeOut)
        axiWrite(flex_pack_pkg::ADDR_ACQ_CTRL, 16'h0501,
            flex_pack_pkg::RESP_OKAY);
        repeat (3) @(posedge clock);
        for (int i = 0; i < 400 && acqBusy !== 1'b0; i++)
            @(posedge clock);
        `CHK("acqDone", 1'b0, acqBusy)
        `CHK("convCount", 4, nConv)
        axiRead(flex_pack_pkg::ADDR_RESULT, {22'h0, lastCode}, '1);
        axiRead(flex_pack_pkg::ADDR_SAMPLE, {18'h0, codeSum, 2'b00},
            '1);
        codeSum = 0;
        // Single scan with calibration, two extra measurements, channel 0
        axiWrite(flex_pack_pkg::ADDR_ACQ_CTRL, 16'h012f,
            flex_pack_pkg::RESP_OKAY);
        repeat (3) @(posedge clock);
        for (int i = 0; i < 400 && acqBusy !== 1'b0; i++)
            @(posedge clock);
        `CHK("acqDone", 1'b0, acqBusy)
        `CHK("convCount", 7, nConv)
        axiRead(flex_pack_pkg::ADDR_SAMPLE, {18'h0, codeSum, 2'b00},
            '1);
        repeat (4) @(posedge clock);
        finish_test();
    end
endmodule
